// >>> rtl/port_dir_pullup_ctrl.v
// Port direction and pull-up option control with read mux and port 3 events.
`timescale 1ns/1ps
`include "port_ctrl_regs.vh"
// Functional notes
// (RL1) Direction 0 drives pin, 1 is input.
// (RL2) Reset loads all direction registers with ones.
// (RL3) Direction registers take bit or byte writes.
// (RL4) Unimplemented direction bits always read one; port 1 bits 3..2 stay writable.
// (RL5) Port 3 output change raises interrupt request.
// (RL6) Software masks port 3 interrupts beforehand.
// (RL7) Alternate inputs need direction bit one.
// (RL8) Timer outputs need direction and latch zero.
// (RL9) Port 0/1 register holds two group enables.
// (RL10) Pull-up only on input-mode pins.
// (RL11) Reset clears all pull-up registers.
// (RL12) Port 0/1 pull-up bits 7..2 read zero.
// (RL13) Port 2 pull-up bits 0..6, bit 7 zero.
// (RL14) Port 3 pull-up bits 0..3, rest zero.
// (RL15) Port 7 pull-up bits 0..2, reset zero.
// (RL16) Pull-up registers take bit or byte writes.
// (RL17) Input-mode read returns pin level.
// (RL18) Output-mode read returns output latch.
// (RL19) Enable inverts direction; pull-up ANDs direction.
module port_dir_pullup_ctrl (
	input wire i_ref_clk,
	input wire i_srst,
	input wire [15:0] i_addr,
	input wire i_wr_byte,
	input wire i_wr_bit,
	input wire [2:0] i_bit_idx,
	input wire i_bit_val,
	input wire [7:0] i_wdata,
	input wire i_rd,
	output reg [7:0] o_rdata,
	output reg o_rvalid,
	input wire [15:0] i_port_addr,
	input wire [3:0] i_p0_latch,
	input wire [1:0] i_p1_latch,
	input wire [6:0] i_p2_latch,
	input wire [3:0] i_p3_latch,
	input wire [3:0] i_p0_pin,
	input wire [1:0] i_p1_pin,
	input wire [6:0] i_p2_pin,
	input wire [3:0] i_p3_pin,
	output wire [3:0] o_p0_oe_n,
	output wire [1:0] o_p1_oe_n,
	output wire [6:0] o_p2_oe_n,
	output wire [3:0] o_p3_oe_n,
	output wire [3:0] o_p5_oe_n,
	output wire [2:0] o_p7_oe_n,
	output wire [1:0] o_p8_oe_n,
	output wire [7:0] o_p9_oe_n,
	output wire [3:0] o_p0_pullup,
	output wire [1:0] o_p1_pullup,
	output wire [6:0] o_p2_pullup,
	output wire [3:0] o_p3_pullup,
	output wire [2:0] o_p7_pullup,
	output wire [7:0] o_p0_rd,
	output wire [7:0] o_p1_rd,
	output wire [7:0] o_p2_rd,
	output wire [7:0] o_p3_rd,
	output reg [3:0] o_ext_int_req
);
	// Decoded register values, fixed bits already applied.
	wire [7:0] dir0, dir1, dir2, dir3, dir5, dir7, dir8, dir9;
	wire [7:0] pu01, pu2, pu3, pu7;
	wire [3:0] p3_change; // Port 3 output level change pulses.
	wire [3:0] p0_rd, p3_rd;
	wire [1:0] p1_rd;
	wire [6:0] p2_rd;

	// Direction registers: reset to ones, bit or byte writes. [RL2] [RL3] [RL4]
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P0)
	) u_dir0 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT0_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir0)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P1)
	) u_dir1 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT1_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir1)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P2)
	) u_dir2 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT2_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir2)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P3)
	) u_dir3 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT3_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir3)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P5)
	) u_dir5 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT5_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir5)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P7)
	) u_dir7 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT7_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir7)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P8)
	) u_dir8 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT8_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir8)
	);
	ctrl_reg8 #(
		.RESET_VAL(`DIR_RESET),
		.FIX_ONE(`DIR_FIX_P9)
	) u_dir9 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT9_DIR),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(dir9)
	);

	// Pull-up option registers: reset clear, masked bits zero. [RL11] [RL16]
	// Port 0/1 group enables with upper bits zero. [RL9] [RL12]
	ctrl_reg8 #(
		.RESET_VAL(`PU_RESET),
		.KEEP(`PU_MASK_P01)
	) u_pu01 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT01_PU),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(pu01)
	);
	// Port 2 per-pin enables, bit 7 zero. [RL13]
	ctrl_reg8 #(
		.RESET_VAL(`PU_RESET),
		.KEEP(`PU_MASK_P2)
	) u_pu2 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT2_PU),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(pu2)
	);
	// Port 3 per-pin enables, bits 7..4 zero. [RL14]
	ctrl_reg8 #(
		.RESET_VAL(`PU_RESET),
		.KEEP(`PU_MASK_P3)
	) u_pu3 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT3_PU),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(pu3)
	);
	// Port 7 per-pin enables, cleared by reset. [RL15]
	ctrl_reg8 #(
		.RESET_VAL(`PU_RESET),
		.KEEP(`PU_MASK_P7)
	) u_pu7 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_sel(i_addr == `ADDR_PORT7_PU),
		.i_wr_byte(i_wr_byte),
		.i_wr_bit(i_wr_bit),
		.i_bit_idx(i_bit_idx),
		.i_bit_val(i_bit_val),
		.i_wdata(i_wdata),
		.o_value(pu7)
	);

	// Ports with read-back and pull-ups: 0 and 1 use group enables from one register.
	port_pin_cell #(.N(4)) u_cell0 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_dir(dir0[3:0]),
		.i_pu({4{pu01[`PU01_BIT_P0]}}),
		.i_latch(i_p0_latch),
		.i_pin(i_p0_pin),
		.o_oe_n(o_p0_oe_n),
		.o_pullup(o_p0_pullup),
		.o_rdata(p0_rd),
		.o_out_change()
	);
	port_pin_cell #(.N(2)) u_cell1 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_dir(dir1[1:0]),
		.i_pu({2{pu01[`PU01_BIT_P1]}}),
		.i_latch(i_p1_latch),
		.i_pin(i_p1_pin),
		.o_oe_n(o_p1_oe_n),
		.o_pullup(o_p1_pullup),
		.o_rdata(p1_rd),
		.o_out_change()
	);
	port_pin_cell #(.N(7)) u_cell2 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_dir(dir2[6:0]),
		.i_pu(pu2[6:0]),
		.i_latch(i_p2_latch),
		.i_pin(i_p2_pin),
		.o_oe_n(o_p2_oe_n),
		.o_pullup(o_p2_pullup),
		.o_rdata(p2_rd),
		.o_out_change()
	);
	// Port 3 also feeds the interrupt request path.
	port_pin_cell #(.N(4)) u_cell3 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_dir(dir3[3:0]),
		.i_pu(pu3[3:0]),
		.i_latch(i_p3_latch),
		.i_pin(i_p3_pin),
		.o_oe_n(o_p3_oe_n),
		.o_pullup(o_p3_pullup),
		.o_rdata(p3_rd),
		.o_out_change(p3_change)
	);

	// Ports without latch read-back here only need enables, plus pull-ups on port 7 alone. [RL1] [RL19]
	assign o_p5_oe_n = dir5[3:0];
	assign o_p8_oe_n = dir8[1:0];
	assign o_p9_oe_n = dir9;
	assign o_p7_oe_n = dir7[2:0];
	assign o_p7_pullup = pu7[2:0] & dir7[2:0]; // [RL10]

	// Port read values, zero-extended.
	assign o_p0_rd = {4'h0, p0_rd}; // [RL17] [RL18]
	assign o_p1_rd = {6'h00, p1_rd};
	assign o_p2_rd = {1'h0, p2_rd};
	assign o_p3_rd = {4'h0, p3_rd};

	// One-cycle interrupt request pulse when a driven port 3 level changes.
	// The masking is left to software, which should mask before driving. [RL5] [RL6]
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_ext_int_req <= 4'h0;
		end else begin
			o_ext_int_req <= p3_change;
		end
	end

	// Registered read answer, one cycle after i_rd; unmapped addresses read zero.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_rdata <= `READ_IDLE;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			case (i_addr)
				`ADDR_PORT0_DIR: o_rdata <= dir0;
				`ADDR_PORT1_DIR: o_rdata <= dir1;
				`ADDR_PORT2_DIR: o_rdata <= dir2;
				`ADDR_PORT3_DIR: o_rdata <= dir3;
				`ADDR_PORT5_DIR: o_rdata <= dir5;
				`ADDR_PORT7_DIR: o_rdata <= dir7;
				`ADDR_PORT8_DIR: o_rdata <= dir8;
				`ADDR_PORT9_DIR: o_rdata <= dir9;
				`ADDR_PORT01_PU: o_rdata <= pu01;
				`ADDR_PORT2_PU: o_rdata <= pu2;
				`ADDR_PORT3_PU: o_rdata <= pu3;
				`ADDR_PORT7_PU: o_rdata <= pu7;
				default: o_rdata <= `READ_IDLE;
			endcase
		end
	end
endmodule // port_dir_pullup_ctrl

// >>> include/port_ctrl_regs.vh
// Register addresses, fixed-bit masks and reset values of the port control block.
`ifndef PORT_CTRL_REGS_VH
`define PORT_CTRL_REGS_VH

// Register addresses on the 16-bit memory-manipulation bus.
`define ADDR_PORT0_DIR 16'hff20
`define ADDR_PORT1_DIR 16'hff21
`define ADDR_PORT2_DIR 16'hff22
`define ADDR_PORT3_DIR 16'hff23
`define ADDR_PORT5_DIR 16'hff25
`define ADDR_PORT7_DIR 16'hff27
`define ADDR_PORT8_DIR 16'hff28
`define ADDR_PORT9_DIR 16'hff29
`define ADDR_PORT2_PU 16'hff32
`define ADDR_PORT3_PU 16'hff33
`define ADDR_PORT7_PU 16'hff37
`define ADDR_PORT01_PU 16'hfff7

// Reset values.
`define DIR_RESET 8'hff
`define PU_RESET 8'h00

// Direction bits forced to one where no pin exists, except port 1 bits 3..2.
`define DIR_FIX_P0 8'hf0
`define DIR_FIX_P1 8'hf0
`define DIR_FIX_P2 8'h80
`define DIR_FIX_P3 8'hf0
`define DIR_FIX_P5 8'hf0
`define DIR_FIX_P7 8'hf8
`define DIR_FIX_P8 8'hfc
`define DIR_FIX_P9 8'h00

// Pull-up bits that are implemented; all others read zero.
`define PU_MASK_P01 8'h03
`define PU_MASK_P2 8'h7f
`define PU_MASK_P3 8'h0f
`define PU_MASK_P7 8'h07

// Bit positions of the two group enables in the port 0/1 pull-up register.
`define PU01_BIT_P0 0
`define PU01_BIT_P1 1

// Unmapped reads return this value.
`define READ_IDLE 8'h00

`endif

// >>> rtl/ctrl_reg8.v
// One 8-bit control register with byte or single-bit write and fixed bits.
`timescale 1ns/1ps
module ctrl_reg8 #(
	parameter [7:0] RESET_VAL = 8'h00, // Value after reset.
	parameter [7:0] FIX_ONE = 8'h00, // Bits that always read one.
	parameter [7:0] KEEP = 8'hff // Bits that may hold a value.
) (
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_sel,
	input wire i_wr_byte,
	input wire i_wr_bit,
	input wire [2:0] i_bit_idx,
	input wire i_bit_val,
	input wire [7:0] i_wdata,
	output wire [7:0] o_value
);
	reg [7:0] val_q; // Stored bits.
	reg [7:0] val_d; // Next value.

	// A bit write touches only the addressed bit, unlike a port latch access.
	always @* begin
		val_d = val_q;
		if (i_sel && i_wr_byte) begin
			val_d = i_wdata;
		end else if (i_sel && i_wr_bit) begin
			val_d[i_bit_idx] = i_bit_val;
		end
	end

	// Synchronous reset, then load.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			val_q <= RESET_VAL;
		end else begin
			val_q <= val_d;
		end
	end

	// Fixed bits override storage so they never read otherwise.
	assign o_value = (val_q & KEEP) | FIX_ONE;
endmodule // ctrl_reg8

// >>> rtl/port_pin_cell.v
// Pin cell for one port: output enable, pull-up, read mux, change detect.
`timescale 1ns/1ps
module port_pin_cell #(
	parameter N = 8 // Pins in the port.
) (
	input wire i_ref_clk,
	input wire i_srst,
	input wire [N-1:0] i_dir,
	input wire [N-1:0] i_pu,
	input wire [N-1:0] i_latch,
	input wire [N-1:0] i_pin,
	output wire [N-1:0] o_oe_n,
	output wire [N-1:0] o_pullup,
	output wire [N-1:0] o_rdata,
	output wire [N-1:0] o_out_change
);
	reg [N-1:0] drv_q; // Driven level seen last cycle.
	genvar g;

	// Per-pin combinational path.
	generate
		for (g = 0; g < N; g = g + 1) begin : g_pin
			// Enable low drives the pin, so it equals the direction bit. [RL1] [RL19]
			assign o_oe_n[g] = i_dir[g];
			// Pull-up only for input-mode pins. [RL10] [RL19]
			assign o_pullup[g] = i_pu[g] & i_dir[g];
			// Input mode reads the pin, output mode the latch. [RL17] [RL18]
			assign o_rdata[g] = i_dir[g] ? i_pin[g] : i_latch[g];
			// A level change while driving is flagged. [RL5]
			assign o_out_change[g] = ~i_dir[g] & (drv_q[g] ^ i_latch[g]);
		end
	endgenerate

	// Remember latch value for change detection.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			drv_q <= {N{1'b0}};
		end else begin
			drv_q <= i_latch;
		end
	end
endmodule // port_pin_cell

// >>> sim/pins_model.sv
// Pin-side model of one port: drives the wire level seen by the block.
`timescale 1ns/1ps
module pins_model #(
	parameter N = 4 // Pins in the port.
) (
	input wire i_ref_clk,
	input wire [N-1:0] i_oe_n,
	input wire [N-1:0] i_pu,
	input wire [N-1:0] i_latch,
	output logic [N-1:0] o_pin
);
	// Toggles every cycle so that a floating pin never shows a steady level.
	logic flip_q = 1'b0;
	always @(posedge i_ref_clk) begin
		flip_q <= ~flip_q;
	end
	// A driven pin follows the latch; a released pin floats unless pulled high.
	assign o_pin = (~i_oe_n & i_latch) | (i_oe_n & (i_pu | {N{flip_q}}));
endmodule // pins_model

// >>> sim/port_dir_pullup_ctrl_sva.sv
// Assertion checker for the port direction and pull-up control block.
`timescale 1ns/1ps
module port_ctrl_chk (
	input wire i_ref_clk,
	input wire i_srst,
	input wire [15:0] i_addr,
	input wire i_wr_byte,
	input wire i_rd,
	input wire [7:0] i_wdata,
	input wire [7:0] o_rdata,
	input wire o_rvalid,
	input wire [3:0] i_p0_latch,
	input wire [3:0] i_p0_pin,
	input wire [3:0] i_p3_latch,
	input wire [3:0] o_p0_oe_n,
	input wire [6:0] o_p2_oe_n,
	input wire [3:0] o_p3_oe_n,
	input wire [6:0] o_p2_pullup,
	input wire [3:0] o_p3_pullup,
	input wire [7:0] o_p0_rd,
	input wire [3:0] o_ext_int_req
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	a_dir_write: assert property (i_wr_byte && i_addr == 16'hff23 |=>
		o_p3_oe_n == $past(i_wdata[3:0])) else $error("port 3 enable not set by write");
	a_rst_dir_ones: assert property ($fell(i_srst) |->
		&o_p0_oe_n && &o_p2_oe_n && &o_p3_oe_n) else $error("pins not input after reset");
	a_rst_pu_off: assert property ($fell(i_srst) |->
		o_p2_pullup == 7'h00 && o_p3_pullup == 4'h0) else $error("pull-up on after reset");
	a_pu_input_only: assert property ((o_p2_pullup & ~o_p2_oe_n) == 7'h00)
		else $error("pull-up on a driving pin");
	a_dir_fixed_one: assert property (i_rd && i_addr == 16'hff23 |=>
		o_rvalid && o_rdata[7:4] == 4'hf) else $error("port 3 direction high nibble wrong");
	a_pu01_fixed_zero: assert property (i_rd && i_addr == 16'hfff7 |=>
		o_rvalid && o_rdata[7:2] == 6'h00) else $error("group pull-up upper bits wrong");
	a_rd_pin_latch: assert property (o_p0_rd[3:0] ==
		((i_p0_pin & o_p0_oe_n) | (i_p0_latch & ~o_p0_oe_n))) else $error("port 0 read mux");
	a_int_on_change: assert property (!o_p3_oe_n[0] && $past(!o_p3_oe_n[0]) &&
		$changed(i_p3_latch[0]) |=> o_ext_int_req[0]) else $error("missing port 3 request");
	a_int_quiet_input: assert property (o_p3_oe_n[1] |=> !o_ext_int_req[1])
		else $error("request from an input pin");
	c_int_seen: cover property (o_ext_int_req == 4'hf);
	c_read_p3: cover property (o_rvalid && o_rdata == 8'hf0);
	c_pullup_on: cover property (o_p3_pullup != 4'h0);
endmodule // port_ctrl_chk
bind port_dir_pullup_ctrl port_ctrl_chk u_chk (.i_ref_clk, .i_srst, .i_addr, .i_wr_byte,
	.i_rd, .i_wdata, .o_rdata, .o_rvalid, .i_p0_latch, .i_p0_pin, .i_p3_latch, .o_p0_oe_n,
	.o_p2_oe_n, .o_p3_oe_n, .o_p2_pullup, .o_p3_pullup, .o_p0_rd, .o_ext_int_req);

// >>> sim/port_dir_pullup_ctrl_tb_top.sv
// Self-checking bench for the port direction and pull-up control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module port_dir_pullup_ctrl_tb_top;
	logic i_ref_clk = 0, i_srst = 1, i_wr_byte = 0, i_wr_bit = 0, i_bit_val = 0, i_rd = 0;
	logic [15:0] i_addr = 16'h0000;
	logic [2:0] i_bit_idx = 3'h0, o_p7_oe_n, o_p7_pullup;
	logic [7:0] i_wdata = 8'h00, o_rdata, o_p0_rd, o_p1_rd, o_p2_rd, o_p3_rd, o_p9_oe_n, w;
	logic [3:0] i_p0_latch = 4'h0, i_p3_latch = 4'h0, i_p0_pin, i_p3_pin, o_p0_oe_n, o_p3_oe_n;
	logic [3:0] o_p5_oe_n, o_p0_pullup, o_p3_pullup, o_ext_int_req;
	logic [1:0] i_p1_latch = 2'h0, i_p1_pin, o_p1_oe_n, o_p8_oe_n, o_p1_pullup;
	logic [6:0] i_p2_latch = 7'h00, i_p2_pin, o_p2_oe_n, o_p2_pullup;
	logic o_rvalid;
	int err_total = 0, n_checks = 0, seed = 57106;
	// Register map: eight direction registers, then four pull-up registers.
	logic [15:0] adr [12] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23, 16'hff25, 16'hff27,
		16'hff28, 16'hff29, 16'hfff7, 16'hff32, 16'hff33, 16'hff37};
	logic [7:0] fix [12] = '{8'hf0, 8'hf0, 8'h80, 8'hf0, 8'hf0, 8'hf8, 8'hfc, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	logic [7:0] keep [12] = '{8'h0f, 8'h0f, 8'h7f, 8'h0f, 8'h0f, 8'h07, 8'h03, 8'hff, 8'h03,
		8'h7f, 8'h0f, 8'h07};
	always #5 i_ref_clk = ~i_ref_clk;
	port_dir_pullup_ctrl i_dut (.i_ref_clk, .i_srst, .i_addr, .i_wr_byte, .i_wr_bit,
		.i_bit_idx, .i_bit_val, .i_wdata, .i_rd, .o_rdata, .o_rvalid, .i_port_addr(16'h0000),
		.i_p0_latch, .i_p1_latch, .i_p2_latch, .i_p3_latch, .i_p0_pin, .i_p1_pin, .i_p2_pin,
		.i_p3_pin, .o_p0_oe_n, .o_p1_oe_n, .o_p2_oe_n, .o_p3_oe_n, .o_p5_oe_n, .o_p7_oe_n,
		.o_p8_oe_n, .o_p9_oe_n, .o_p0_pullup, .o_p1_pullup, .o_p2_pullup, .o_p3_pullup,
		.o_p7_pullup, .o_p0_rd, .o_p1_rd, .o_p2_rd, .o_p3_rd, .o_ext_int_req);
	// One pin model per port that has pin inputs.
	pins_model #(.N(4)) m0 (.i_ref_clk, .i_oe_n(o_p0_oe_n), .i_pu(o_p0_pullup),
		.i_latch(i_p0_latch), .o_pin(i_p0_pin));
	pins_model #(.N(2)) m1 (.i_ref_clk, .i_oe_n(o_p1_oe_n), .i_pu(o_p1_pullup),
		.i_latch(i_p1_latch), .o_pin(i_p1_pin));
	pins_model #(.N(7)) m2 (.i_ref_clk, .i_oe_n(o_p2_oe_n), .i_pu(o_p2_pullup),
		.i_latch(i_p2_latch), .o_pin(i_p2_pin));
	pins_model #(.N(4)) m3 (.i_ref_clk, .i_oe_n(o_p3_oe_n), .i_pu(o_p3_pullup),
		.i_latch(i_p3_latch), .o_pin(i_p3_pin));
	// Writable bits take the data; fixed bits keep their level.
	function automatic logic [7:0] exp_val(input int i, input logic [7:0] d);
		return (d & keep[i]) | fix[i];
	endfunction
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk) begin i_addr <= a; i_wdata <= d; i_wr_byte <= 1'b1; end
		@(posedge i_ref_clk) i_wr_byte <= 1'b0;
	endtask
	task automatic wb(input logic [15:0] a, input logic [2:0] b, input logic v);
		@(posedge i_ref_clk) begin i_addr <= a; i_bit_idx <= b; i_bit_val <= v; i_wr_bit <= 1; end
		@(posedge i_ref_clk) i_wr_bit <= 1'b0;
	endtask
	// Read data is answered exactly one cycle after the request edge.
	task automatic rd(input logic [15:0] a, input logic [7:0] ex);
		@(posedge i_ref_clk) begin i_addr <= a; i_rd <= 1'b1; end
		@(posedge i_ref_clk) i_rd <= 1'b0;
		#1 `CHK("rvalid", 1'b1, o_rvalid)
		`CHK("rdata", ex, o_rdata)
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		for (int i = 0; i < 12; i++) rd(adr[i], i < 8 ? 8'hff : 8'h00);
		rd(16'hff30, 8'h00);
		$display("test reset values done");
		for (int k = 0; k < 4; k++) for (int i = 0; i < 12; i++) begin
			w = $random(seed);
			wr(adr[i], w);
			rd(adr[i], exp_val(i, w));
		end
		wr(16'hff32, 8'h00);
		wb(16'hff32, 3'h7, 1'b1);
		wb(16'hff32, 3'h3, 1'b1);
		rd(16'hff32, 8'h08);
		wr(16'hff23, 8'hff);
		wb(16'hff23, 3'h1, 1'b0);
		wb(16'hff23, 3'h6, 1'b0);
		rd(16'hff23, 8'hfd);
		// Remaining ports: direction drives the enables, pull-ups only on inputs.
		wr(16'hff22, 8'h55);
		wr(16'hff25, 8'h0a);
		wr(16'hff27, 8'h05);
		wr(16'hff28, 8'h01);
		wr(16'hff29, 8'h3c);
		wr(16'hff32, 8'h7f);
		wr(16'hff37, 8'h07);
		#1 `CHK("p2 oe", 7'h55, o_p2_oe_n)
		`CHK("p5 oe", 4'ha, o_p5_oe_n)
		`CHK("p7 oe", 3'h5, o_p7_oe_n)
		`CHK("p8 oe", 2'h1, o_p8_oe_n)
		`CHK("p9 oe", 8'h3c, o_p9_oe_n)
		`CHK("p2 pu", 7'h55, o_p2_pullup)
		`CHK("p7 pu", 3'h5, o_p7_pullup)
		`CHK("p2 rd", 8'h55 | {1'b0, i_p2_latch & 7'h2a}, o_p2_rd)
		$display("test register access done");
		// Group pull-up on port 0 with two pins driving, then port 1 only.
		wr(16'hfff7, 8'h01);
		wr(16'hff20, 8'h0c);
		#1 `CHK("p0 oe", 4'hc, o_p0_oe_n)
		`CHK("p0 pu", 4'hc, o_p0_pullup)
		for (int k = 0; k < 8; k++) begin
			@(posedge i_ref_clk) begin i_p0_latch <= $random(seed); i_p2_latch <= $random(seed); end
			@(posedge i_ref_clk) #1 `CHK("p0 rd", 4'hc | (i_p0_latch & 4'h3), o_p0_rd[3:0])
		end
		wr(16'hff21, 8'hfe);
		wr(16'hfff7, 8'h02);
		#1 `CHK("p0 pu off", 4'h0, o_p0_pullup)
		`CHK("p1 pu", 2'h2, o_p1_pullup)
		`CHK("p1 rd", 8'h02 | {6'h00, i_p1_latch & 2'h1}, o_p1_rd)
		wr(16'hff33, 8'h0f);
		wr(16'hff23, 8'hf3);
		#1 `CHK("p3 pu", 4'h3, o_p3_pullup)
		// Pins 3:2 set up as timer outputs (driving, latch low), pins 1:0 as alternate inputs.
		`CHK("p3 rd", 8'h03 | {4'h0, i_p3_latch & 4'hc}, o_p3_rd)
		$display("test pull-up and read done");
		// Output-mode toggles raise requests; input-mode toggles must not.
		wr(16'hff23, 8'h00);
		@(posedge i_ref_clk) i_p3_latch <= ~i_p3_latch;
		// Software would mask these requests first; the bench only watches them.
		@(posedge i_ref_clk) #1 `CHK("p3 req", 4'hf, o_ext_int_req)
		@(posedge i_ref_clk) #1 `CHK("p3 req end", 4'h0, o_ext_int_req)
		wr(16'hff23, 8'hff);
		@(posedge i_ref_clk) i_p3_latch <= ~i_p3_latch;
		@(posedge i_ref_clk) #1 `CHK("p3 req in", 4'h0, o_ext_int_req)
		$display("test port 3 requests done");
		conclude();
	end
	// Cuts a hang short and reports it as a mismatch.
	initial begin
		#200000;
		err_total++;
		$display("[ERR] watchdog exp done got hang");
		conclude();
	end
endmodule // port_dir_pullup_ctrl_tb_top
